// ==== rtl/scu_store_cond.sv ====
// How it works
// - address is base plus sign-extended offset
// - doubleword misaligned low three bits raise address error
// - doubleword stored only if link set, result flag
// - paired form decoded from fixed opcode fields
// - high register upper, low register lower doubleword
// - paired form uses base register alone, no offset
// - two writes held locked as one quad-word
// - paired result one on success, zero on failure
// - outcome depends on link flag, address and whether an uncached access is allowed
// - paired address must match recorded link address
// - failure events apply to quad-word block for a paired link, doubleword block otherwise
// - own loads to block never break link
// - raises translation, address, reserved and watch exceptions
// - exception between link and store breaks link
// - cacheless build may drop the link address
// - paired form reserved when paired ops disabled
// - paired success needs flag and match; clears flag
// - exception return between link and store breaks link
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "scu_map.svh"
module scu_store_cond #(
  parameter int PA_W = 40,
  parameter bit HAS_LINK_ADDR = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // pipeline issue
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] base_val_i,
  input wire logic [63:0] src_lo_val_i,
  input wire logic [63:0] src_hi_val_i,
  output logic busy_o,
  // register write-back and exceptions
  output logic wb_valid_o,
  output logic [4:0] wb_idx_o,
  output logic [63:0] wb_data_o,
  output logic exc_valid_o,
  output scu_pkg::scu_exc_t exc_code_o,
  output logic [63:0] exc_vaddr_o,
  // address translation
  output logic xl_req_o,
  output logic [63:0] xl_vaddr_o,
  input wire logic xl_ack_i,
  input wire logic [PA_W-1:0] xl_paddr_i,
  input wire logic [2:0] xl_cca_i,
  input wire scu_pkg::scu_exc_t xl_exc_i,
  input wire logic xl_watch_i,
  // memory store port
  output logic mem_req_o,
  output logic [PA_W-1:0] mem_addr_o,
  output logic [63:0] mem_wdata_o,
  output logic [2:0] mem_cca_o,
  output logic mem_lock_o,
  input wire logic mem_ack_i,
  // link events
  input wire logic ll_set_i,
  input wire logic ll_pair_i,
  input wire logic [PA_W-1:0] ll_paddr_i,
  input wire logic remote_store_i,
  input wire logic [PA_W-1:0] remote_paddr_i,
  input wire logic exception_return_i,
  input wire logic exc_taken_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------
  // state
  // ----------------------------------------
  scu_pkg::scu_state_t state_ff, nxt_state;
  scu_pkg::scu_exc_t exc_ff, nxt_exc;
  logic pair_ff, nxt_pair;
  logic [63:0] vaddr_ff, nxt_vaddr;
  logic [PA_W-1:0] maddr_ff, nxt_maddr;
  logic [63:0] wdata_ff, nxt_wdata;
  logic [63:0] hi_ff, nxt_hi;
  logic [2:0] cca_ff, nxt_cca;
  logic [4:0] idx_ff, nxt_idx;
  logic result_ff, nxt_result;
  logic [1:0] ctrl_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic link_flag;
  logic link_pair;
  logic [PA_W-1:0] link_addr;
  scu_pkg::scu_op_t dec_op;
  logic [4:0] dec_lo;
  logic [63:0] dec_off;

  wire uncached_link_support = ctrl_ff[`SCU_CTRL_UNC_LINK_BIT];
  wire no_paired_ops = ctrl_ff[`SCU_CTRL_NO_PAIR_BIT];

  // ----------------------------------------
  // decode and address
  // ----------------------------------------
  scu_decode u_dec (
    .instr_i(instr_i),
    .no_paired_ops_i(no_paired_ops),
    .op_o(dec_op),
    .lo_idx_o(dec_lo),
    .hi_idx_o(),
    .offset_o(dec_off)
  );

  wire in_idle = state_ff == scu_pkg::SCU_IDLE;
  wire take = in_idle && issue_valid_i && (dec_op != scu_pkg::SCU_OP_NONE);
  wire is_pair = dec_op == scu_pkg::SCU_OP_PAIR;
  wire is_resv = dec_op == scu_pkg::SCU_OP_RESV;
  wire [63:0] ea = is_pair ? base_val_i : base_val_i + dec_off;
  wire dw_misal = ea[`SCU_DWORD_ALIGN_BITS-1:0] != '0;
  wire qw_misal = ea[`SCU_QUAD_ALIGN_BITS-1:0] != '0;
  wire misal = is_pair ? qw_misal : dw_misal;

  // ----------------------------------------
  // success decision at translation answer
  // ----------------------------------------
  wire uncached = (xl_cca_i == `SCU_CCA_UNCACHED) || (xl_cca_i == `SCU_CCA_UNCACHED_ACC);
  // uncached access without support is unpredictable; it is made to fail safely
  wire cca_ok = !uncached || uncached_link_support;
  wire addr_match = !HAS_LINK_ADDR || (xl_paddr_i == link_addr);
  wire pair_ok = link_flag && link_pair && addr_match;
  wire can_store = cca_ok && (pair_ff ? pair_ok : link_flag);
  wire xl_fault = (xl_exc_i != scu_pkg::SCU_EXC_NONE) || xl_watch_i;
  wire [PA_W-1:0] next_dw = maddr_ff + PA_W'(`SCU_DWORD_BYTES);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_exc = exc_ff;
    nxt_pair = pair_ff;
    nxt_vaddr = vaddr_ff;
    nxt_maddr = maddr_ff;
    nxt_wdata = wdata_ff;
    nxt_hi = hi_ff;
    nxt_cca = cca_ff;
    nxt_idx = idx_ff;
    nxt_result = result_ff;
    case (state_ff)
      scu_pkg::SCU_IDLE: begin
        if (take) begin
          nxt_pair = is_pair;
          nxt_vaddr = ea;
          nxt_idx = dec_lo;
          nxt_wdata = src_lo_val_i;
          nxt_hi = src_hi_val_i;
          if (is_resv) begin
            nxt_exc = scu_pkg::SCU_EXC_RESV_INSTR;
            nxt_state = scu_pkg::SCU_EXC;
          end else if (misal) begin
            nxt_exc = scu_pkg::SCU_EXC_ADDR_ERR;
            nxt_state = scu_pkg::SCU_EXC;
          end else begin
            nxt_state = scu_pkg::SCU_XLATE;
          end
        end
      end
      scu_pkg::SCU_XLATE: begin
        if (xl_ack_i) begin
          nxt_maddr = xl_paddr_i;
          nxt_cca = xl_cca_i;
          if (xl_exc_i != scu_pkg::SCU_EXC_NONE) begin
            nxt_exc = xl_exc_i;
            nxt_state = scu_pkg::SCU_EXC;
          end else if (xl_watch_i) begin
            nxt_exc = scu_pkg::SCU_EXC_WATCH;
            nxt_state = scu_pkg::SCU_EXC;
          end else if (can_store) begin
            nxt_state = scu_pkg::SCU_ST_LO;
          end else begin
            nxt_result = 1'b0;
            nxt_state = scu_pkg::SCU_WBACK;
          end
        end
      end
      scu_pkg::SCU_ST_LO: begin
        if (mem_ack_i) begin
          if (pair_ff) begin
            nxt_maddr = next_dw;
            nxt_wdata = hi_ff;
            nxt_state = scu_pkg::SCU_ST_HI;
          end else begin
            nxt_result = 1'b1;
            nxt_state = scu_pkg::SCU_WBACK;
          end
        end
      end
      scu_pkg::SCU_ST_HI: begin
        if (mem_ack_i) begin
          nxt_result = 1'b1;
          nxt_state = scu_pkg::SCU_WBACK;
        end
      end
      scu_pkg::SCU_WBACK: nxt_state = scu_pkg::SCU_IDLE;
      scu_pkg::SCU_EXC: nxt_state = scu_pkg::SCU_IDLE;
      default: nxt_state = scu_pkg::SCU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= scu_pkg::SCU_IDLE;
      exc_ff <= scu_pkg::SCU_EXC_NONE;
      pair_ff <= 1'b0;
      vaddr_ff <= '0;
      maddr_ff <= '0;
      wdata_ff <= '0;
      hi_ff <= '0;
      cca_ff <= '0;
      idx_ff <= '0;
      result_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      exc_ff <= nxt_exc;
      pair_ff <= nxt_pair;
      vaddr_ff <= nxt_vaddr;
      maddr_ff <= nxt_maddr;
      wdata_ff <= nxt_wdata;
      hi_ff <= nxt_hi;
      cca_ff <= nxt_cca;
      idx_ff <= nxt_idx;
      result_ff <= nxt_result;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire storing = (state_ff == scu_pkg::SCU_ST_LO) || (state_ff == scu_pkg::SCU_ST_HI);
  assign busy_o = !in_idle;
  assign xl_req_o = state_ff == scu_pkg::SCU_XLATE;
  assign xl_vaddr_o = vaddr_ff;
  assign mem_req_o = storing;
  assign mem_addr_o = maddr_ff;
  assign mem_wdata_o = wdata_ff;
  assign mem_cca_o = cca_ff;
  // lock spans both halves so no observer sees half a quad-word
  assign mem_lock_o = storing && pair_ff;
  assign wb_valid_o = state_ff == scu_pkg::SCU_WBACK;
  assign wb_idx_o = idx_ff;
  assign wb_data_o = {63'h0, result_ff};
  assign exc_valid_o = state_ff == scu_pkg::SCU_EXC;
  assign exc_code_o = exc_ff;
  assign exc_vaddr_o = vaddr_ff;

  // ----------------------------------------
  // link monitor
  // ----------------------------------------
  wire sc_done = wb_valid_o && pair_ff;
  scu_link_monitor #(
    .PA_W(PA_W),
    .HAS_LINK_ADDR(HAS_LINK_ADDR)
  ) u_mon (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .ll_set_i(ll_set_i),
    .ll_pair_i(ll_pair_i),
    .ll_paddr_i(ll_paddr_i),
    .remote_store_i(remote_store_i),
    .remote_paddr_i(remote_paddr_i),
    .exception_return_i(exception_return_i),
    .exc_i(exc_taken_i || exc_valid_o),
    .sc_done_i(sc_done),
    .link_flag_o(link_flag),
    .link_pair_o(link_pair),
    .link_addr_o(link_addr)
  );

  // ----------------------------------------
  // wishbone registers
  // ----------------------------------------
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire sel_ctrl = wb_adr_i == `SCU_CTRL_OFS;
  wire sel_status = wb_adr_i == `SCU_STATUS_OFS;
  wire sel_lo = wb_adr_i == `SCU_LINK_LO_OFS;
  wire sel_hi = wb_adr_i == `SCU_LINK_HI_OFS;
  wire [63:0] link_wide = 64'(link_addr);
  wire [31:0] status_word = {28'h0, result_ff, busy_o, link_pair, link_flag};
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_ff} :
                       sel_status ? status_word :
                       sel_lo ? link_wide[31:0] :
                       sel_hi ? link_wide[63:32] : 32'h0;
  wire ctrl_wr = wb_req && wb_we_i && sel_ctrl && wb_sel_i[0];

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_ff <= `SCU_CTRL_RESET;
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) begin
        rdata_ff <= rd_mux;
      end
      if (ctrl_wr) begin
        ctrl_ff <= wb_dat_i[1:0];
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence pair_lo_done;
    state_ff == scu_pkg::SCU_ST_LO && pair_ff && mem_ack_i;
  endsequence
  sequence hi_held;
    (state_ff == scu_pkg::SCU_ST_HI && mem_lock_o) [*1];
  endsequence

  ea_form_a: assert property (
    take && dec_op == scu_pkg::SCU_OP_DWORD |=> vaddr_ff == $past(base_val_i + dec_off))
    else $error("doubleword address not base plus offset");
  dword_align_a: assert property (
    take && dec_op == scu_pkg::SCU_OP_DWORD && ea[2:0] != 3'h0
    |=> exc_valid_o && exc_code_o == scu_pkg::SCU_EXC_ADDR_ERR ##1 !mem_req_o)
    else $error("misaligned doubleword not faulted");
  dword_result_a: assert property (
    state_ff == scu_pkg::SCU_XLATE && xl_ack_i && !xl_fault && !pair_ff && cca_ok
    |=> $past(link_flag) ? mem_req_o : (wb_valid_o && wb_data_o == 64'h0))
    else $error("doubleword outcome not tied to link flag");
  pair_addr_a: assert property (
    take && is_pair |=> vaddr_ff == $past(base_val_i))
    else $error("paired address not base register");
  pair_data_a: assert property (
    pair_lo_done |=> mem_addr_o == $past(mem_addr_o) + PA_W'(8) && mem_wdata_o == hi_ff)
    else $error("upper doubleword misplaced");
  pair_lock_a: assert property (
    pair_lo_done |=> hi_held)
    else $error("lock dropped between halves");
  pair_fail_a: assert property (
    state_ff == scu_pkg::SCU_XLATE && xl_ack_i && !xl_fault && pair_ff && !addr_match
    |=> wb_valid_o && wb_data_o == 64'h0 && !mem_req_o)
    else $error("paired store on address mismatch");
  resv_pair_a: assert property (
    take && instr_i[6] && no_paired_ops
    |=> exc_valid_o && exc_code_o == scu_pkg::SCU_EXC_RESV_INSTR)
    else $error("paired form not reserved when disabled");
  link_clear_a: assert property (
    wb_valid_o && pair_ff && !ll_set_i |=> !link_flag)
    else $error("link flag left set after paired store");
  exc_quiet_a: assert property (
    state_ff == scu_pkg::SCU_XLATE && xl_ack_i && xl_fault
    |=> exc_valid_o && !mem_req_o ##1 !wb_valid_o && !mem_req_o)
    else $error("faulting store touched memory or register");
endmodule
`default_nettype wire

// ==== rtl/scu_map.svh ====
`ifndef SCU_MAP_SVH
`define SCU_MAP_SVH
// ----------------------------------------
// instruction encoding
// ----------------------------------------
`define SCU_MAJOR_OPC 6'h1f
`define SCU_FUNC_SC 6'h27
`define SCU_PAIR_ZERO 4'h0
`define SCU_OFFSET_LSB 7
`define SCU_OFFSET_MSB 15
// ----------------------------------------
// alignment
// ----------------------------------------
`define SCU_DWORD_ALIGN_BITS 3
`define SCU_QUAD_ALIGN_BITS 4
`define SCU_DWORD_BYTES 8
// ----------------------------------------
// cache attribute codes seen as uncached
// ----------------------------------------
`define SCU_CCA_UNCACHED 3'h2
`define SCU_CCA_UNCACHED_ACC 3'h7
// ----------------------------------------
// register offsets, fields and resets
// ----------------------------------------
`define SCU_CTRL_OFS 8'h00
`define SCU_STATUS_OFS 8'h04
`define SCU_LINK_LO_OFS 8'h08
`define SCU_LINK_HI_OFS 8'h0c
`define SCU_CTRL_UNC_LINK_BIT 0
`define SCU_CTRL_NO_PAIR_BIT 1
`define SCU_CTRL_RESET 2'h0
`define SCU_ST_LINK_BIT 0
`define SCU_ST_PAIR_BIT 1
`define SCU_ST_BUSY_BIT 2
`define SCU_ST_RESULT_BIT 3
`endif

// ==== rtl/scu_pkg.sv ====
`default_nettype none
package scu_pkg;
  typedef enum logic [2:0] {
    SCU_EXC_NONE = 3'b000,
    SCU_EXC_TLB_REFILL = 3'b001,
    SCU_EXC_TLB_INVALID = 3'b010,
    SCU_EXC_TLB_MODIFIED = 3'b011,
    SCU_EXC_ADDR_ERR = 3'b100,
    SCU_EXC_RESV_INSTR = 3'b101,
    SCU_EXC_WATCH = 3'b110
  } scu_exc_t;
  typedef enum logic [2:0] {
    SCU_IDLE = 3'b000,
    SCU_XLATE = 3'b001,
    SCU_ST_LO = 3'b010,
    SCU_ST_HI = 3'b011,
    SCU_WBACK = 3'b100,
    SCU_EXC = 3'b101
  } scu_state_t;
  typedef enum logic [1:0] {
    SCU_OP_NONE = 2'b00,
    SCU_OP_DWORD = 2'b01,
    SCU_OP_PAIR = 2'b10,
    SCU_OP_RESV = 2'b11
  } scu_op_t;
endpackage
`default_nettype wire

// ==== rtl/scu_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "scu_map.svh"
module scu_decode (
  // instruction word
  input wire logic [31:0] instr_i,
  input wire logic no_paired_ops_i,
  // decoded fields
  output scu_pkg::scu_op_t op_o,
  output logic [4:0] lo_idx_o,
  output logic [4:0] hi_idx_o,
  output logic [63:0] offset_o
);
  wire is_family = (instr_i[31:26] == `SCU_MAJOR_OPC) && (instr_i[5:0] == `SCU_FUNC_SC);
  wire is_dword = is_family && !instr_i[6];
  wire pair_form = is_family && instr_i[6];
  // a paired encoding with dirty spare bits or paired ops switched off is reserved
  wire pair_ok = pair_form && (instr_i[10:7] == `SCU_PAIR_ZERO) && !no_paired_ops_i;
  wire [8:0] off9 = instr_i[`SCU_OFFSET_MSB:`SCU_OFFSET_LSB];
  assign op_o = is_dword ? scu_pkg::SCU_OP_DWORD :
                pair_ok ? scu_pkg::SCU_OP_PAIR :
                pair_form ? scu_pkg::SCU_OP_RESV : scu_pkg::SCU_OP_NONE;
  assign lo_idx_o = instr_i[20:16];
  assign hi_idx_o = instr_i[15:11];
  assign offset_o = {{55{off9[8]}}, off9};
endmodule
`default_nettype wire

// ==== rtl/scu_link_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module scu_link_monitor #(
  parameter int PA_W = 40,
  parameter bit HAS_LINK_ADDR = 1'b1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // load-linked capture
  input wire logic ll_set_i,
  input wire logic ll_pair_i,
  input wire logic [PA_W-1:0] ll_paddr_i,
  // breaking events
  input wire logic remote_store_i,
  input wire logic [PA_W-1:0] remote_paddr_i,
  input wire logic exception_return_i,
  input wire logic exc_i,
  input wire logic sc_done_i,
  // link state
  output logic link_flag_o,
  output logic link_pair_o,
  output logic [PA_W-1:0] link_addr_o
);
  logic link_flag_ff;
  logic link_pair_ff;
  logic [PA_W-1:0] link_addr_ff;
  // block is a quad-word for a paired link, a doubleword otherwise
  wire quad_hit = remote_paddr_i[PA_W-1:4] == link_addr_ff[PA_W-1:4];
  wire dword_hit = remote_paddr_i[PA_W-1:3] == link_addr_ff[PA_W-1:3];
  // cacheless build keeps no address: any remote store breaks the link
  wire block_hit = !HAS_LINK_ADDR || (link_pair_ff ? quad_hit : dword_hit);
  // local loads have no path in here, so they never break the link
  wire breaks = (remote_store_i && block_hit) || exception_return_i || exc_i || sc_done_i;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      link_flag_ff <= 1'b0;
      link_pair_ff <= 1'b0;
      link_addr_ff <= '0;
    end else if (ll_set_i) begin
      link_flag_ff <= 1'b1;
      link_pair_ff <= ll_pair_i;
      link_addr_ff <= HAS_LINK_ADDR ? ll_paddr_i : '0;
    end else if (breaks) begin
      link_flag_ff <= 1'b0;
    end
  end
  assign link_flag_o = link_flag_ff;
  assign link_pair_o = link_pair_ff;
  assign link_addr_o = link_addr_ff;

  break_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (exception_return_i || exc_i) && !ll_set_i |=> !link_flag_ff)
    else $error("link survived an exception or return");
  quad_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    remote_store_i && link_pair_ff && quad_hit && !ll_set_i |=> !link_flag_ff)
    else $error("remote store to linked quad-word ignored");
endmodule
`default_nettype wire

// ==== sim/scu_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---
// memory and translation far side
// ---
module scu_mem_model #(
  parameter int PA_W = 40
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // bench controls
  input wire logic slow_i,
  input wire logic [2:0] cca_i,
  input wire scu_pkg::scu_exc_t exc_i,
  input wire logic watch_i,
  // translation
  input wire logic xl_req_i,
  input wire logic [63:0] xl_vaddr_i,
  output logic xl_ack_o,
  output logic [PA_W-1:0] xl_paddr_o,
  output logic [2:0] xl_cca_o,
  output scu_pkg::scu_exc_t xl_exc_o,
  output logic xl_watch_o,
  // store port
  input wire logic mem_req_i,
  input wire logic [PA_W-1:0] mem_addr_i,
  input wire logic [63:0] mem_wdata_i,
  output logic mem_ack_o
);
  // stores seen, oldest first, as {address, data}
  logic [PA_W+63:0] wr_q[$];
  logic [2:0] cnt_ff;
  // answer lines toggle outside an answer so stale values never look valid
  always @(posedge core_clk_i) begin
    xl_ack_o <= 1'b0;
    mem_ack_o <= 1'b0;
    xl_paddr_o <= ~xl_paddr_o;
    xl_cca_o <= ~xl_cca_o;
    xl_exc_o <= scu_pkg::scu_exc_t'(~xl_exc_o);
    xl_watch_o <= ~xl_watch_o;
    if (srst_i) begin
      cnt_ff <= 3'h0;
      xl_paddr_o <= '0;
      xl_cca_o <= 3'h0;
      xl_exc_o <= scu_pkg::SCU_EXC_NONE;
      xl_watch_o <= 1'b0;
    end else if ((xl_req_i || mem_req_i) && !xl_ack_o && !mem_ack_o) begin
      cnt_ff <= cnt_ff + 3'h1;
      if (cnt_ff >= (slow_i ? 3'h3 : 3'h0)) begin
        cnt_ff <= 3'h0;
        if (xl_req_i) begin
          xl_ack_o <= 1'b1;
          xl_paddr_o <= xl_vaddr_i[PA_W-1:0];
          xl_cca_o <= cca_i;
          xl_exc_o <= exc_i;
          xl_watch_o <= watch_i;
        end else begin
          mem_ack_o <= 1'b1;
          wr_q.push_back({mem_addr_i, mem_wdata_i});
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_store_conditional_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_store_conditional_unit;
  localparam int PA_W = 40;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic issue_valid_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [63:0] base_val_i = 64'h0;
  logic [63:0] src_lo_val_i = 64'h0;
  logic [63:0] src_hi_val_i = 64'h0;
  logic ll_set_i = 1'b0;
  logic ll_pair_i = 1'b0;
  logic [PA_W-1:0] ll_paddr_i = '0;
  logic remote_store_i = 1'b0;
  logic [PA_W-1:0] remote_paddr_i = '0;
  logic exception_return_i = 1'b0;
  logic exc_taken_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic slow = 1'b0;
  logic [2:0] cca_sel = 3'h0;
  scu_pkg::scu_exc_t xe_sel = scu_pkg::SCU_EXC_NONE;
  logic wt_sel = 1'b0;
  logic busy_o, wb_valid_o, exc_valid_o, xl_req_o, xl_ack_i, xl_watch_i;
  logic mem_req_o, mem_lock_o, mem_ack_i, wb_ack_o;
  logic [4:0] wb_idx_o;
  logic [63:0] wb_data_o, exc_vaddr_o, xl_vaddr_o, mem_wdata_o;
  logic [PA_W-1:0] xl_paddr_i, mem_addr_o;
  logic [2:0] xl_cca_i, mem_cca_o;
  logic [31:0] wb_dat_o;
  scu_pkg::scu_exc_t exc_code_o, xl_exc_i;
  // bench model state
  logic m_link = 1'b0;
  logic m_pair = 1'b0;
  logic m_unc = 1'b0;
  logic m_nopair = 1'b0;
  logic [39:0] m_addr = 40'h0;
  logic [103:0] exp_q[$];
  logic [31:0] seed = 32'h01ff;
  int bad_count = 0;
  int num_checks = 0;
  // ---
  // clock, design and far side
  // ---
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  scu_store_cond #(.PA_W(PA_W), .HAS_LINK_ADDR(1'b1)) u_dut (
    .core_clk_i, .srst_i, .issue_valid_i, .instr_i, .base_val_i, .src_lo_val_i,
    .src_hi_val_i, .busy_o, .wb_valid_o, .wb_idx_o, .wb_data_o, .exc_valid_o, .exc_code_o,
    .exc_vaddr_o, .xl_req_o, .xl_vaddr_o, .xl_ack_i, .xl_paddr_i, .xl_cca_i, .xl_exc_i,
    .xl_watch_i, .mem_req_o, .mem_addr_o, .mem_wdata_o, .mem_cca_o, .mem_lock_o, .mem_ack_i,
    .ll_set_i, .ll_pair_i, .ll_paddr_i, .remote_store_i, .remote_paddr_i, .exception_return_i,
    .exc_taken_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o);
  scu_mem_model #(.PA_W(PA_W)) u_mem (
    .core_clk_i, .srst_i, .slow_i(slow), .cca_i(cca_sel), .exc_i(xe_sel), .watch_i(wt_sel),
    .xl_req_i(xl_req_o), .xl_vaddr_i(xl_vaddr_o), .xl_ack_o(xl_ack_i), .xl_paddr_o(xl_paddr_i),
    .xl_cca_o(xl_cca_i), .xl_exc_o(xl_exc_i), .xl_watch_o(xl_watch_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i));
  // ---
  // helpers
  // ---
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [103:0] g, input logic [103:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // one-cycle link event; m: {exc, exception_return, remote, load-linked}
  task automatic ev(input logic [3:0] m, input logic [39:0] a, input logic p);
    @(posedge core_clk_i);
    {exc_taken_i, exception_return_i, remote_store_i, ll_set_i} <= m;
    {ll_pair_i, ll_paddr_i, remote_paddr_i} <= {p, a, a};
    @(posedge core_clk_i);
    {exc_taken_i, exception_return_i, remote_store_i, ll_set_i} <= 4'h0;
    {ll_paddr_i, remote_paddr_i} <= {~a, ~a};
    if (m[0]) {m_link, m_pair, m_addr} = {1'b1, p, a};
    else if ((m[1] && m_addr[39:4] == a[39:4]) || m[2] || m[3]) m_link = 1'b0;
  endtask
  task automatic run_sc(input logic pr, input logic [63:0] base, input logic [8:0] off);
    logic [63:0] ea, lo, hi;
    logic [31:0] r;
    logic ok;
    scu_pkg::scu_exc_t code;
    r = rnd();
    lo = {rnd(), rnd()};
    hi = {rnd(), rnd()};
    ea = pr ? base : base + {{55{off[8]}}, off};
    if (pr && (m_nopair || r[31:29] == 3'h7)) code = scu_pkg::SCU_EXC_RESV_INSTR;
    else if (pr ? ea[3:0] != 4'h0 : ea[2:0] != 3'h0) code = scu_pkg::SCU_EXC_ADDR_ERR;
    else if (xe_sel != scu_pkg::SCU_EXC_NONE) code = xe_sel;
    else if (wt_sel) code = scu_pkg::SCU_EXC_WATCH;
    else code = scu_pkg::SCU_EXC_NONE;
    ok = m_link && (m_unc || (cca_sel != 3'h2 && cca_sel != 3'h7));
    ok = ok && (!pr || (m_pair && m_addr == ea[39:0]));
    if (code == scu_pkg::SCU_EXC_NONE && ok) begin
      exp_q.push_back({ea[39:0], lo});
      if (pr) exp_q.push_back({ea[39:0] + 40'h8, hi});
    end
    @(posedge core_clk_i);
    issue_valid_i <= 1'b1;
    instr_i <= {6'h1f, r[9:5], r[4:0],
      pr ? {r[14:10], (r[31:29] == 3'h7) ? 4'h9 : 4'h0, 1'b1} : {off, 1'b0}, 6'h27};
    {base_val_i, src_lo_val_i, src_hi_val_i} <= {base, lo, hi};
    @(posedge core_clk_i);
    issue_valid_i <= 1'b0;
    do begin
      @(posedge core_clk_i);
      chk(busy_o, 1'b1);
      if (mem_req_o === 1'b1) chk({mem_lock_o, mem_cca_o}, {pr, cca_sel});
    end while (wb_valid_o !== 1'b1 && exc_valid_o !== 1'b1);
    chk(exc_valid_o, code != scu_pkg::SCU_EXC_NONE);
    chk(wb_valid_o, code == scu_pkg::SCU_EXC_NONE);
    if (code != scu_pkg::SCU_EXC_NONE) begin
      chk(exc_code_o, code);
      if (code != scu_pkg::SCU_EXC_RESV_INSTR) chk(exc_vaddr_o, ea);
      m_link = 1'b0;
    end else begin
      chk(wb_idx_o, r[4:0]);
      chk(wb_data_o, ok);
      if (pr) m_link = 1'b0;
    end
    chk(u_mem.wr_q.size(), exp_q.size());
    while (exp_q.size() > 0 && u_mem.wr_q.size() > 0) begin
      chk(u_mem.wr_q.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    u_mem.wr_q.delete();
  endtask
  // ---
  // sequence
  // ---
  initial begin
    logic [31:0] r, q;
    logic [63:0] base, la;
    logic [8:0] off;
    logic pr;
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    wb_rw(1'b1, 8'h30, 32'hffff_ffff, q);
    wb_rw(1'b0, 8'h30, 32'h0, q);
    chk(q, 32'h0);
    for (int ph = 0; ph < 3; ph++) begin
      wb_rw(1'b0, 8'h00, 32'h0, q);
      chk(q, ph == 0 ? 32'h0 : 32'(ph - 1));
      wb_rw(1'b1, 8'h00, 32'(ph), q);
      {m_nopair, m_unc} = ph[1:0];
      for (int i = 0; i < 60; i++) begin
        r = rnd();
        q = rnd();
        pr = r[0];
        base = {rnd(), rnd()};
        off = q[8:0];
        // mostly aligned, so most operations get past the alignment test
        if (r[3:1] != 3'h0) {base[3:0], off[2:0]} = 7'h0;
        la = pr ? base : base + {{55{off[8]}}, off};
        if (r[4] && r[21]) la[4] = ~la[4];
        cca_sel = r[7:5];
        slow = r[8];
        wt_sel = r[11:9] == 3'h6;
        xe_sel = scu_pkg::SCU_EXC_NONE;
        if (r[11:9] == 3'h7) xe_sel = scu_pkg::scu_exc_t'(r[12] ? 3'h3 : (r[13] ? 3'h2 : 3'h1));
        if (r[16:14] != 3'h0) begin
          ev(4'h1, la[39:0], pr ^ (r[17] & r[22]));
          case (r[20:18])
            3'h1: ev(4'h2, la[39:0], 1'b0);
            3'h2: if (m_pair) ev(4'h2, la[39:0] ^ 40'h100, 1'b0);
            3'h3: ev(4'h4, la[39:0], 1'b0);
            3'h4: ev(4'h8, la[39:0], 1'b0);
            default: ;
          endcase
        end
        run_sc(pr, base, off);
        wb_rw(1'b0, 8'h04, 32'h0, q);
        chk(q[2:0], {1'b0, m_pair, m_link});
      end
    end
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
